// ===== hw/dma_ch_pkg.sv
package dma_ch_pkg;
  // Descriptor geometry
  localparam int          DESC_WORDS      = 8;
  localparam logic [31:0] DESC_ALIGN_MASK = 32'h0000_001F;
  localparam logic [31:0] DESC7_RST       = 32'h0008_0000;
  localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
  localparam logic [2:0]  LAST_WORD       = 3'h7;
  localparam int          CNT_W           = 16;
  localparam int          NB_W            = 20;
  localparam int          CH_W            = 3;
  localparam int          MOD_W           = 5;
  localparam int          ML_W            = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_DESC_END = 8'h1C;
  localparam logic [7:0] OFS_CSR      = 8'h20;
  localparam logic [7:0] OFS_ERR      = 8'h24;
  localparam logic [7:0] OFS_IEN_SET  = 8'h28;
  localparam logic [7:0] OFS_IEN_CLR  = 8'h2C;
  // Descriptor word indexes
  localparam logic [2:0] W_SRC = 3'h0;
  localparam logic [2:0] W_ATR = 3'h1;
  localparam logic [2:0] W_NB  = 3'h2;
  localparam logic [2:0] W_SLA = 3'h3;
  localparam logic [2:0] W_DST = 3'h4;
  localparam logic [2:0] W_CIT = 3'h5;
  localparam logic [2:0] W_DLA = 3'h6;
  localparam logic [2:0] W_CTL = 3'h7;
  // Descriptor fields
  localparam int SIZE_LSB  = 16;
  localparam int SMOD_LSB  = 18;
  localparam int DMOD_LSB  = 23;
  localparam int MLOFF_LSB = 20;
  localparam int DMLOE_BIT = 30;
  localparam int SMLOE_BIT = 31;
  localparam int CURRENT_ITERATION_COUNT_LSB = 16;
  localparam int START_BIT = 16;
  localparam int INTMJ_BIT = 17;
  localparam int INTHF_BIT = 18;
  localparam int DISABLE_REQUEST_ON_COMPLETION_BIT  = 19;
  localparam int ESG_BIT   = 20;
  localparam int MJLE_BIT  = 21;
  localparam int MJLCH_LSB = 22;
  localparam int MNLE_BIT  = 25;
  localparam int MNLCH_LSB = 26;
  // Status bits
  localparam int CSR_ERQ   = 0;
  localparam int CSR_ACT   = 1;
  localparam int CSR_DONE  = 2;
  localparam int CSR_INT   = 3;
  localparam int CSR_ERR   = 4;
  localparam int CSR_START = 8;
  localparam int ERR_CH_LSB = 8;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Engine states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_READ  = 6'h02,
    ST_WRITE = 6'h04,
    ST_MINOR = 6'h08,
    ST_MAJOR = 6'h10,
    ST_FETCH = 6'h20
  } state_t;
endpackage : dma_ch_pkg

// ===== hw/dma_addr_step.sv
module dma_addr_step
  import dma_ch_pkg::*;
#(
  parameter int AW = 32
) (
  // Address and step
  input  wire logic [AW-1:0]    addr_in,
  input  wire logic [AW-1:0]    delta_in,
  input  wire logic [MOD_W-1:0] mod_in,
  input  wire logic             wrap_in,
  // Result
  output logic      [AW-1:0]    addr_out
);
  logic [AW-1:0] sum;
  logic [AW-1:0] mask;

  if (AW < 8) begin : g_chk
    $error("dma_addr_step: AW too small");
  end

  always_comb begin
    sum = addr_in + delta_in;
    // Low bits move, upper bits stay inside the window
    if (mod_in == '0 || !wrap_in) begin
      mask = '1;
    end else begin
      mask = ~({AW{1'b1}} << mod_in);
    end
    addr_out = (addr_in & ~mask) | (sum & mask); // RULE9
  end
endmodule : dma_addr_step

// ===== hw/dma_channel_ctrl.sv
// Notes on behaviour
// [RULE1] Descriptors sit on 32-byte boundaries, else error
// [RULE2] Reload copies descriptor word for word
// [RULE3] Scatter-gather loads next descriptor at major end
// [RULE4] Software clears stop-on-done bit when chaining
// [RULE5] Sign-extended minor offset added after minor loop
// [RULE6] Minor link requests on every count decrement
// [RULE7] Major link requests when count is exhausted
// [RULE8] Software clears done before writing link fields
// [RULE9] Modulo confines stepped address to power-two window
// [RULE10] Auto-stop clears request enable at major end
// [RULE11] Descriptor interrupt enables, set or cleared by mask
// [RULE12] Signed last adjustments applied at major end
// [RULE13] Peripheral requests only served while enabled
// [RULE14] Software start runs one minor loop
// [RULE15] Current iteration count readable at any time
// [RULE16] Byte count reads back the working value
// [RULE17] Error register names channel and error kind
// [RULE18] Status flags cleared by written mask
// [RULE19] Source misaligned to access width raises error
// [RULE20] Count zero sets done, reloads from beginning count
//
// The register addresses and the AHB-Lite register port were decided locally.
module dma_channel_ctrl
  import dma_ch_pkg::*;
#(
  parameter int          AW    = 32,
  parameter logic [3:0]  CH_ID = 4'h0
) (
  // Clock, reset, enable
  input  wire logic            CORE_CLK_IN,
  input  wire logic            RST_IN,
  input  wire logic            CE_IN,
  // AHB-Lite slave
  input  wire logic            HSEL_IN,
  input  wire logic [31:0]     HADDR_IN,
  input  wire logic [1:0]      HTRANS_IN,
  input  wire logic            HWRITE_IN,
  input  wire logic [2:0]      HSIZE_IN,
  input  wire logic [31:0]     HWDATA_IN,
  input  wire logic            HREADY_IN,
  output logic      [31:0]     HRDATA_OUT,
  output logic                 HREADYOUT_OUT,
  output logic                 HRESP_OUT,
  // Peripheral request, link and interrupt
  input  wire logic            HW_REQ_IN,
  output logic                 LINK_REQ_OUT,
  output logic      [CH_W-1:0] LINK_CH_OUT,
  output logic                 CH_INT_OUT,
  // Memory master
  output logic                 MEM_REQ_OUT,
  output logic                 MEM_WRITE_OUT,
  output logic      [31:0]     MEM_ADDR_OUT,
  output logic      [1:0]      MEM_SIZE_OUT,
  output logic      [31:0]     MEM_WDATA_OUT,
  input  wire logic [31:0]     MEM_RDATA_IN,
  input  wire logic            MEM_ACK_IN
);
  if (AW != 32) begin : g_chk
    $error("dma_channel_ctrl: only 32-bit addresses");
  end

  state_t            state_reg, state_next;
  logic [31:0]       desc_reg [DESC_WORDS];
  logic [31:0]       desc_next [DESC_WORDS];
  logic [NB_W-1:0]   minor_loop_byte_count_work_reg, minor_loop_byte_count_work_next;
  logic [2:0]        fetch_idx_reg, fetch_idx_next;
  logic              erq_reg, erq_next, active_reg, active_next;
  logic              done_reg, done_next, int_reg, int_next;
  logic [2:0]        err_reg, err_next;
  logic              start_pend_reg, start_pend_next;
  logic              link_req_reg, link_req_next;
  logic [CH_W-1:0]   link_ch_reg, link_ch_next;
  logic              mem_req_reg, mem_req_next, mem_write_reg, mem_write_next;
  logic [31:0]       mem_addr_reg, mem_addr_next, mem_wdata_reg, mem_wdata_next;
  logic [1:0]        mem_size_reg, mem_size_next;
  logic [7:0]        addr_reg, addr_next;
  logic              wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
  logic              hready_reg, hready_next;
  logic [31:0]       hrdata_reg, hrdata_next, rd_word;
  logic [1:0]        size;
  logic [1:0]        amask;
  logic [NB_W-1:0]   abytes;
  logic [CNT_W-1:0]  current_iteration_count, biter;
  logic [31:0]       mloff_ext, s_delta, d_delta, src_step, dst_step;
  logic              s_wrap, d_wrap, launch_rd, take, sw_start;

  assign size      = desc_reg[W_ATR][SIZE_LSB +: 2];
  assign amask     = {size[1], size[1] | size[0]};
  assign abytes    = NB_W'(1) << size;
  assign current_iteration_count     = desc_reg[W_CIT][CURRENT_ITERATION_COUNT_LSB +: CNT_W];
  assign biter     = desc_reg[W_CTL][CNT_W-1:0];
  assign mloff_ext = 32'(signed'(desc_reg[W_NB][MLOFF_LSB +: ML_W]));

  dma_addr_step #(.AW(AW)) u_src_step (
    .addr_in  (desc_reg[W_SRC]),
    .delta_in (s_delta),
    .mod_in   (desc_reg[W_ATR][SMOD_LSB +: MOD_W]),
    .wrap_in  (s_wrap),
    .addr_out (src_step)
  );

  dma_addr_step #(.AW(AW)) u_dst_step (
    .addr_in  (desc_reg[W_DST]),
    .delta_in (d_delta),
    .mod_in   (desc_reg[W_ATR][DMOD_LSB +: MOD_W]),
    .wrap_in  (d_wrap),
    .addr_out (dst_step)
  );

  // Register read view
  always_comb begin
    rd_word = '0;
    if (addr_reg <= OFS_DESC_END) begin
      rd_word = desc_reg[addr_reg[4:2]]; // RULE15
      if (addr_reg[4:2] == W_NB) begin
        rd_word[NB_W-1:0] = minor_loop_byte_count_work_reg; // RULE16
      end
    end else if (addr_reg == OFS_CSR) begin
      rd_word[CSR_ERQ]  = erq_reg;
      rd_word[CSR_ACT]  = active_reg;
      rd_word[CSR_DONE] = done_reg;
      rd_word[CSR_INT]  = int_reg;
      rd_word[CSR_ERR]  = |err_reg;
    end else if (addr_reg == OFS_ERR) begin
      rd_word[2:0] = err_reg; // RULE17
      rd_word[ERR_CH_LSB +: 4] = CH_ID;
    end
  end

  always_comb begin
    state_next       = state_reg;
    desc_next        = desc_reg;
    minor_loop_byte_count_work_next = minor_loop_byte_count_work_reg;
    fetch_idx_next   = fetch_idx_reg;
    erq_next         = erq_reg;
    active_next      = active_reg;
    done_next        = done_reg;
    int_next         = int_reg;
    err_next         = err_reg;
    link_req_next    = 1'b0;
    link_ch_next     = link_ch_reg;
    mem_req_next     = mem_req_reg;
    mem_write_next   = mem_write_reg;
    mem_addr_next    = mem_addr_reg;
    mem_wdata_next   = mem_wdata_reg;
    mem_size_next    = mem_size_reg;
    hrdata_next      = hrdata_reg;
    hready_next      = 1'b1;
    addr_next        = addr_reg;
    wr_pend_next     = 1'b0;
    rd_pend_next     = 1'b0;
    s_delta          = 32'(signed'(desc_reg[W_ATR][CNT_W-1:0]));
    d_delta          = 32'(signed'(desc_reg[W_CIT][CNT_W-1:0]));
    s_wrap           = 1'b1;
    d_wrap           = 1'b1;
    launch_rd        = 1'b0;
    take             = 1'b0;
    sw_start         = 1'b0;
    // Bus address phase
    if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
      addr_next    = HADDR_IN[7:0];
      wr_pend_next = HWRITE_IN;
      rd_pend_next = !HWRITE_IN;
      hready_next  = HWRITE_IN;
    end
    if (rd_pend_reg) begin
      hrdata_next = rd_word;
    end
    // Bus write data phase
    if (wr_pend_reg) begin
      if (addr_reg <= OFS_DESC_END) begin
        desc_next[addr_reg[4:2]] = HWDATA_IN;
        if (addr_reg[4:2] == W_NB) begin
          minor_loop_byte_count_work_next = HWDATA_IN[NB_W-1:0];
        end
      end else if (addr_reg == OFS_CSR) begin
        erq_next = HWDATA_IN[CSR_ERQ];
        if (HWDATA_IN[CSR_DONE]) done_next = 1'b0; // RULE18
        if (HWDATA_IN[CSR_INT]) int_next = 1'b0; // RULE18
        if (HWDATA_IN[CSR_ERR]) err_next = '0; // RULE18
        sw_start = HWDATA_IN[CSR_START]; // RULE14
      end else if (addr_reg == OFS_IEN_SET) begin
        desc_next[W_CTL][INTMJ_BIT] = desc_reg[W_CTL][INTMJ_BIT] | HWDATA_IN[0]; // RULE11
        desc_next[W_CTL][INTHF_BIT] = desc_reg[W_CTL][INTHF_BIT] | HWDATA_IN[1]; // RULE11
      end else if (addr_reg == OFS_IEN_CLR) begin
        desc_next[W_CTL][INTMJ_BIT] = desc_reg[W_CTL][INTMJ_BIT] & ~HWDATA_IN[0]; // RULE11
        desc_next[W_CTL][INTHF_BIT] = desc_reg[W_CTL][INTHF_BIT] & ~HWDATA_IN[1]; // RULE11
      end
    end
    // Engine
    unique case (state_reg)
      ST_IDLE: begin
        if (start_pend_reg || (HW_REQ_IN && erq_reg)) begin // RULE13 RULE14
          take        = 1'b1;
          active_next = 1'b1;
          launch_rd   = 1'b1;
        end
      end
      ST_READ: begin
        if (MEM_ACK_IN) begin
          desc_next[W_SRC] = src_step; // RULE9
          mem_wdata_next   = MEM_RDATA_IN;
          mem_addr_next    = desc_reg[W_DST];
          mem_write_next   = 1'b1;
          state_next       = ST_WRITE;
          if ((desc_reg[W_DST][1:0] & amask) != '0) begin
            err_next[2]  = 1'b1;
            mem_req_next = 1'b0;
            active_next  = 1'b0;
            state_next   = ST_IDLE;
          end
        end
      end
      ST_WRITE: begin
        if (MEM_ACK_IN) begin
          desc_next[W_DST] = dst_step; // RULE9
          mem_req_next     = 1'b0;
          if (minor_loop_byte_count_work_reg <= abytes) begin
            state_next = ST_MINOR;
          end else begin
            minor_loop_byte_count_work_next = minor_loop_byte_count_work_reg - abytes; // RULE16
            launch_rd        = 1'b1;
          end
        end
      end
      ST_MINOR: begin
        minor_loop_byte_count_work_next = desc_reg[W_NB][NB_W-1:0];
        s_delta = mloff_ext;
        d_delta = mloff_ext;
        s_wrap  = 1'b0;
        d_wrap  = 1'b0;
        if (desc_reg[W_NB][SMLOE_BIT]) desc_next[W_SRC] = src_step; // RULE5
        if (desc_reg[W_NB][DMLOE_BIT]) desc_next[W_DST] = dst_step; // RULE5
        desc_next[W_CIT][CURRENT_ITERATION_COUNT_LSB +: CNT_W] = current_iteration_count - 1'b1;
        if (desc_reg[W_CTL][MNLE_BIT]) begin
          link_req_next = 1'b1; // RULE6
          link_ch_next  = desc_reg[W_CTL][MNLCH_LSB +: CH_W];
        end
        if (current_iteration_count <= CNT_W'(1)) begin
          state_next = ST_MAJOR;
        end else begin
          if (desc_reg[W_CTL][INTHF_BIT] && (current_iteration_count - 1'b1) == (biter >> 1)) int_next = 1'b1; // RULE11
          active_next = 1'b0;
          state_next  = ST_IDLE;
        end
      end
      ST_MAJOR: begin
        done_next = 1'b1; // RULE20
        desc_next[W_CIT][CURRENT_ITERATION_COUNT_LSB +: CNT_W] = biter; // RULE20
        if (desc_reg[W_CTL][INTMJ_BIT]) int_next = 1'b1; // RULE11
        if (desc_reg[W_CTL][DISABLE_REQUEST_ON_COMPLETION_BIT]) erq_next = 1'b0; // RULE10
        if (desc_reg[W_CTL][MJLE_BIT]) begin
          link_req_next = 1'b1; // RULE7
          link_ch_next  = desc_reg[W_CTL][MJLCH_LSB +: CH_W];
        end
        s_delta = desc_reg[W_SLA];
        d_delta = desc_reg[W_DLA];
        s_wrap  = 1'b0;
        d_wrap  = 1'b0;
        desc_next[W_SRC] = src_step; // RULE12
        active_next = 1'b0;
        state_next  = ST_IDLE;
        if (!desc_reg[W_CTL][ESG_BIT]) begin
          desc_next[W_DST] = dst_step; // RULE12
        end else if ((desc_reg[W_DLA] & DESC_ALIGN_MASK) != '0) begin
          err_next[0] = 1'b1; // RULE1
        end else begin
          fetch_idx_next = '0; // RULE3
          mem_addr_next  = desc_reg[W_DLA];
          mem_write_next = 1'b0;
          mem_size_next  = SIZE_WORD;
          mem_req_next   = 1'b1;
          active_next    = 1'b1;
          state_next     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (MEM_ACK_IN) begin
          desc_next[fetch_idx_reg] = MEM_RDATA_IN; // RULE2
          mem_addr_next  = mem_addr_reg + WORD_STEP;
          fetch_idx_next = fetch_idx_reg + 1'b1;
          if (fetch_idx_reg == W_NB) minor_loop_byte_count_work_next = MEM_RDATA_IN[NB_W-1:0];
          if (fetch_idx_reg == LAST_WORD) begin
            mem_req_next = 1'b0;
            active_next  = 1'b0;
            sw_start     = MEM_RDATA_IN[START_BIT];
            state_next   = ST_IDLE;
          end
        end
      end
    endcase
    if (launch_rd) begin
      mem_addr_next  = desc_reg[W_SRC];
      mem_write_next = 1'b0;
      mem_size_next  = size;
      if ((desc_reg[W_SRC][1:0] & amask) != '0) begin
        err_next[1] = 1'b1; // RULE19
        active_next = 1'b0;
        state_next  = ST_IDLE;
      end else begin
        mem_req_next = 1'b1;
        state_next   = ST_READ;
      end
    end
    start_pend_next = (start_pend_reg & ~take) | sw_start;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < DESC_WORDS; i++) begin
        desc_reg[i] <= '0;
      end
      desc_reg[W_CTL] <= DESC7_RST; // RULE4
      minor_loop_byte_count_work_reg <= '0;
      fetch_idx_reg   <= '0;
      erq_reg         <= 1'b0;
      active_reg      <= 1'b0;
      done_reg        <= 1'b0;
      int_reg         <= 1'b0;
      err_reg         <= '0;
      start_pend_reg  <= 1'b0;
      link_req_reg    <= 1'b0;
      link_ch_reg     <= '0;
      mem_req_reg     <= 1'b0;
      mem_write_reg   <= 1'b0;
      mem_addr_reg    <= '0;
      mem_wdata_reg   <= '0;
      mem_size_reg    <= '0;
      addr_reg        <= '0;
      wr_pend_reg     <= 1'b0;
      rd_pend_reg     <= 1'b0;
      hready_reg      <= 1'b1;
      hrdata_reg      <= '0;
    end else if (CE_IN) begin
      state_reg       <= state_next;
      desc_reg        <= desc_next;
      minor_loop_byte_count_work_reg <= minor_loop_byte_count_work_next;
      fetch_idx_reg   <= fetch_idx_next;
      erq_reg         <= erq_next;
      active_reg      <= active_next;
      done_reg        <= done_next;
      int_reg         <= int_next;
      err_reg         <= err_next;
      start_pend_reg  <= start_pend_next;
      link_req_reg    <= link_req_next;
      link_ch_reg     <= link_ch_next;
      mem_req_reg     <= mem_req_next;
      mem_write_reg   <= mem_write_next;
      mem_addr_reg    <= mem_addr_next;
      mem_wdata_reg   <= mem_wdata_next;
      mem_size_reg    <= mem_size_next;
      addr_reg        <= addr_next;
      wr_pend_reg     <= wr_pend_next;
      rd_pend_reg     <= rd_pend_next;
      hready_reg      <= hready_next;
      hrdata_reg      <= hrdata_next;
    end
  end

  assign HRDATA_OUT    = hrdata_reg;
  assign HREADYOUT_OUT = hready_reg;
  assign HRESP_OUT     = 1'b0;
  assign LINK_REQ_OUT  = link_req_reg;
  assign LINK_CH_OUT   = link_ch_reg;
  assign CH_INT_OUT    = int_reg;
  assign MEM_REQ_OUT   = mem_req_reg;
  assign MEM_WRITE_OUT = mem_write_reg;
  assign MEM_ADDR_OUT  = mem_addr_reg;
  assign MEM_SIZE_OUT  = mem_size_reg;
  assign MEM_WDATA_OUT = mem_wdata_reg;

  // Checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN || !CE_IN);

  a_fetch_align: assert property (state_reg == ST_FETCH && fetch_idx_reg == '0 |-> mem_addr_reg[4:0] == '0) // RULE1
    else $error("descriptor fetch misaligned");
  a_fetch_copy: assert property (state_reg == ST_FETCH && MEM_ACK_IN ##1 CE_IN
    |-> desc_reg[$past(fetch_idx_reg)] == $past(MEM_RDATA_IN)) // RULE2
    else $error("descriptor word not copied");
  a_sg_reload: assert property (state_reg == ST_MAJOR && desc_reg[W_CTL][ESG_BIT]
    && desc_reg[W_DLA][4:0] == '0 |=> state_reg == ST_FETCH && mem_req_reg) // RULE3
    else $error("no descriptor fetch after major end");
  a_minor_offset: assert property (state_reg == ST_MINOR && desc_reg[W_NB][SMLOE_BIT]
    |=> desc_reg[W_SRC] == $past(desc_reg[W_SRC]) + $past(mloff_ext)) // RULE5
    else $error("minor offset not applied");
  a_minor_link: assert property (state_reg == ST_MINOR && desc_reg[W_CTL][MNLE_BIT]
    |=> LINK_REQ_OUT && LINK_CH_OUT == $past(desc_reg[W_CTL][MNLCH_LSB +: CH_W])) // RULE6
    else $error("minor link request missing");
  a_major_link: assert property (state_reg == ST_MAJOR && desc_reg[W_CTL][MJLE_BIT] |=> LINK_REQ_OUT) // RULE7
    else $error("major link request missing");
  a_auto_stop: assert property (state_reg == ST_MAJOR && desc_reg[W_CTL][DISABLE_REQUEST_ON_COMPLETION_BIT] && !wr_pend_reg
    |=> !erq_reg) // RULE10
    else $error("request enable not cleared");
  a_req_gate: assert property (state_reg == ST_IDLE && !erq_reg && !start_pend_reg |=> state_reg == ST_IDLE) // RULE13
    else $error("request served while disabled");
  a_src_align: assert property (state_reg == ST_READ |-> (mem_addr_reg[1:0] & amask) == '0) // RULE19
    else $error("misaligned source read issued");
  a_done_reload: assert property (state_reg == ST_MAJOR
    |=> done_reg && current_iteration_count == $past(biter)) // RULE20
    else $error("done or count reload missing");
  c_major_end: cover property (state_reg == ST_MAJOR ##1 done_reg);
  c_sg_fetch: cover property (state_reg == ST_FETCH ##[1:40] state_reg == ST_IDLE);
  c_src_error: cover property (err_reg[1]);
endmodule : dma_channel_ctrl

// ===== dv/dma_mem_model.sv
module dma_mem_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Access request from the engine
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [31:0] wdata_in,
  // Stall control and answer
  input  wire logic        slow_in,
  output logic      [31:0] rdata_out,
  output logic             ack_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] mem [0:1023];
  logic [31:0] last_reg;
  logic [1:0]  wait_reg;

  // Word memory; answers at once or after a stall, read bus shows a stale inverse when idle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out   <= 1'b0;
      rdata_out <= 32'h0000_0000;
      last_reg  <= 32'h0000_0000;
      wait_reg  <= 2'h0;
    end else begin
      ack_out   <= 1'b0;
      rdata_out <= ~last_reg;
      if (req_in && !ack_out) begin
        if (slow_in && wait_reg != 2'h3) begin
          wait_reg <= wait_reg + 2'h1;
        end else begin
          ack_out  <= 1'b1;
          wait_reg <= 2'h0;
          if (write_in) begin
            mem[addr_in[11:2]] <= wdata_in;
          end else begin
            rdata_out <= mem[addr_in[11:2]];
            last_reg  <= mem[addr_in[11:2]];
          end
        end
      end
    end
  end
endmodule : dma_mem_model

// ===== dv/descriptor_dma_channel_control_bench.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, (e), (g)); end end
module descriptor_dma_channel_control_bench
  import dma_ch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk, rst, hsel, hwrite, hw_req, slow, hready, hresp, link, ch_int;
  logic [1:0]      htrans, msize;
  logic [31:0]     haddr, hwdata, hrdata, maddr, mwdata, mrdata, rd, seed, w7;
  logic            mreq, mwr, mack;
  logic [CH_W-1:0] link_ch;
  logic [CH_W-1:0] link_q [$];
  logic [31:0]     m [8];
  int              bad_count, n_checks, n_acc;

  dma_channel_ctrl #(.AW(32), .CH_ID(4'h5)) dma_channel_ctrl_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HW_REQ_IN(hw_req), .LINK_REQ_OUT(link), .LINK_CH_OUT(link_ch), .CH_INT_OUT(ch_int),
    .MEM_REQ_OUT(mreq), .MEM_WRITE_OUT(mwr), .MEM_ADDR_OUT(maddr), .MEM_SIZE_OUT(msize),
    .MEM_WDATA_OUT(mwdata), .MEM_RDATA_IN(mrdata), .MEM_ACK_IN(mack));

  dma_mem_model dma_mem_model_inst (
    .clk_in(clk), .rst_in(rst), .req_in(mreq), .write_in(mwr), .addr_in(maddr), .size_in(msize),
    .wdata_in(mwdata), .slow_in(slow), .rdata_out(mrdata), .ack_out(mack));

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Link pulse and access monitor, random memory stalls
  always @(posedge clk) begin
    if (link === 1'b1) link_q.push_back(link_ch);
    if (mack === 1'b1) begin
      n_acc++;
      `CHK("size", SIZE_WORD, msize)
    end
    slow <= next_rand() > 32'h8000_0000;
  end

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("reg %h", a), e, rd & msk)
    `CHK("hresp", 1'b0, hresp)
  endtask : rdchk

  task automatic load(input logic [31:0] d [8]);
    for (int i = 0; i < 8; i++) ahb(1'b1, 8'(i * 4), d[i]);
  endtask : load

  task automatic wait_idle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 100; i++) begin
      ahb(1'b0, OFS_CSR, 32'h0000_0000);
      if (rd[CSR_ACT] === 1'b0) break;
    end
    `CHK("idle", 1'b0, rd[CSR_ACT])
  endtask : wait_idle

  task automatic go();
    ahb(1'b1, OFS_CSR, 32'h0000_0100);
    wait_idle();
  endtask : go

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial begin
    #500_000;
    bad_count++;
    close_out();
  end

  initial begin
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0; hwdata = '0;
    hw_req = 1'b0; slow = 1'b0; seed = 32'h0000_ED39; bad_count = 0; n_checks = 0; n_acc = 0;
    for (int i = 0; i < 1024; i++) dma_mem_model_inst.mem[i] = next_rand();
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(OFS_DESC_END, 32'hFFFF_FFFF, DESC7_RST);
    rdchk(OFS_CSR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(OFS_ERR, 32'hFFFF_FFFF, 32'h0000_0500);
    // Two-iteration transfer with minor and major links
    ahb(1'b1, OFS_CSR, 32'h0000_0004);
    load('{32'h0000_0100, 32'h0002_0004, 32'h0000_0008, 32'hFFFF_FFF0,
           32'h0000_0200, 32'h0002_0004, 32'hFFFF_FFF0, 32'h0F62_0002});
    go();
    for (int i = 0; i < 2; i++) `CHK("dst", dma_mem_model_inst.mem[64+i], dma_mem_model_inst.mem[128+i])
    rdchk(8'h14, 32'hFFFF_0000, 32'h0001_0000);
    `CHK("link0", 3'h3, link_q[0])
    go();
    for (int i = 2; i < 4; i++) `CHK("dst", dma_mem_model_inst.mem[64+i], dma_mem_model_inst.mem[128+i])
    rdchk(OFS_CSR, 32'h0000_000C, 32'h0000_000C);
    `CHK("int", 1'b1, ch_int)
    rdchk(8'h14, 32'hFFFF_0000, 32'h0002_0000);
    rdchk(8'h00, 32'hFFFF_FFFF, 32'h0000_0100);
    rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0200);
    `CHK("links", 3, link_q.size())
    `CHK("link2", 3'h5, link_q[2])
    ahb(1'b1, OFS_CSR, 32'h0000_0004);
    rdchk(OFS_CSR, 32'h0000_000C, 32'h0000_0008);
    ahb(1'b1, OFS_CSR, 32'h0000_0008);
    @(posedge clk);
    `CHK("int clr", 1'b0, ch_int)
    // Hardware requests gated, modulo destination, auto-stop, masked interrupt
    load('{32'h0000_0140, 32'h0182_0004, 32'h0000_0010, 32'h0000_0000,
           32'h0000_0300, 32'h0001_0004, 32'h0000_0000, 32'h000A_0001});
    ahb(1'b1, OFS_IEN_SET, 32'h0000_0002);
    rdchk(OFS_DESC_END, 32'h0006_0000, 32'h0006_0000);
    ahb(1'b1, OFS_IEN_CLR, 32'h0000_0003);
    rdchk(OFS_DESC_END, 32'h0006_0000, 32'h0000_0000);
    n_acc = 0;
    hw_req <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK("gated", 0, n_acc)
    ahb(1'b1, OFS_CSR, 32'h0000_0001);
    wait_idle();
    hw_req <= 1'b0;
    `CHK("accesses", 8, n_acc)
    rdchk(OFS_CSR, 32'h0000_0005, 32'h0000_0004);
    for (int i = 0; i < 2; i++) `CHK("wrap", dma_mem_model_inst.mem[82+i], dma_mem_model_inst.mem[192+i])
    `CHK("int off", 1'b0, ch_int)
    ahb(1'b1, OFS_CSR, 32'h0000_0004);
    // Misaligned source
    ahb(1'b1, 8'h00, 32'h0000_0102);
    go();
    rdchk(OFS_ERR, 32'hFFFF_FFFF, 32'h0000_0502);
    rdchk(OFS_CSR, 32'h0000_0010, 32'h0000_0010);
    ahb(1'b1, OFS_CSR, 32'h0000_0010);
    rdchk(OFS_ERR, 32'hFFFF_FFFF, 32'h0000_0500);
    // Scatter-gather: misaligned then aligned next descriptor
    ahb(1'b1, 8'h00, 32'h0000_0100);
    ahb(1'b1, 8'h18, 32'h0000_0404);
    ahb(1'b1, OFS_DESC_END, 32'h0010_0001);
    go();
    rdchk(OFS_ERR, 32'hFFFF_FFFF, 32'h0000_0501);
    ahb(1'b1, OFS_CSR, 32'h0000_0014);
    w7 = dma_mem_model_inst.mem[263] & 32'hFFEE_FFFF;
    dma_mem_model_inst.mem[263] = w7;
    m = '{32'hFFFF_FFFF, 32'h0FFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
          32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1FFE_FFFF};
    ahb(1'b1, 8'h18, 32'h0000_0400);
    go();
    for (int i = 0; i < 8; i++) rdchk(8'(i * 4), m[i], dma_mem_model_inst.mem[256+i] & m[i]);
    close_out();
  end
endmodule : descriptor_dma_channel_control_bench
